// ===== hw/rcmc_top.sv
// receive channel marker / channel clock output for one framer port
`timescale 1ns/10ps

module rcmc_top (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic RX_LINE_CLOCK,
    input wire logic RX_SYSTEM_CLOCK,
    input wire logic RX_ES_ENABLE,
    input wire logic RX_FRAME_SYNC,
    input wire logic E1_MODE,
    input wire logic CLOCK_OUT_SELECT,
    input wire logic GAPPED_CLOCK_SELECT,
    input wire logic GAP_FBIT_EN,
    input wire logic [rcmc_pkg::E1_CHANNELS-1:0] MARKER_MASK,
    input wire logic [rcmc_pkg::E1_CHANNELS-1:0] GAP_CHANNEL_EN,
    output logic RX_CHANNEL_OUT
);
    rcmc_pkg::rcmc_cfg_s cfg_in;
    rcmc_pkg::rcmc_sys_s sys_r;
    rcmc_pkg::rcmc_sys_s sys_nxt;
    rcmc_pkg::rcmc_link_s lnk_r;
    rcmc_pkg::rcmc_link_s lnk_nxt;
    logic timing_clk;
    logic [7:0] last_bit;
    logic [7:0] pos_nxt;
    logic [7:0] ch_pos;
    logic [4:0] ch_idx;
    logic [2:0] bit_idx;
    logic fbit_slot;
    logic rx_channel_clock_out;

    // config pins come from sys-clock logic: no pin synchroniser
    assign cfg_in.e1_mode = E1_MODE;
    assign cfg_in.clock_out_select = CLOCK_OUT_SELECT;
    assign cfg_in.gapped_clock_select = GAPPED_CLOCK_SELECT;
    assign cfg_in.gap_fbit_en = GAP_FBIT_EN;
    assign cfg_in.marker_mask = MARKER_MASK;
    assign cfg_in.gap_channel_en = GAP_CHANNEL_EN;

    // line or system clock
    // static selection; change only while held in reset
    assign timing_clk = RX_ES_ENABLE ? RX_SYSTEM_CLOCK : RX_LINE_CLOCK;

    // system side: hold a changed word and toggle a request
    always_comb begin
        sys_nxt = sys_r;
        sys_nxt.ack_s1 = lnk_r.seen;
        sys_nxt.ack_s2 = sys_r.ack_s1;
        if (sys_r.pending) begin
            if (sys_r.ack_s2 == sys_r.req_tgl) begin
                sys_nxt.pending = 1'b0;
            end
        end else if (cfg_in != sys_r.hold) begin
            sys_nxt.hold = cfg_in;
            sys_nxt.req_tgl = ~sys_r.req_tgl;
            sys_nxt.pending = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sys_r <= '0;
        end else begin
            sys_r <= sys_nxt;
        end
    end

    // link side position within the frame
    always_comb begin
        last_bit = lnk_r.shadow.e1_mode ? rcmc_pkg::E1_LAST_BIT : rcmc_pkg::T1_LAST_BIT;
        if (RX_FRAME_SYNC || lnk_r.pos == last_bit) begin
            pos_nxt = rcmc_pkg::FRAME_FIRST_BIT;
        end else begin
            pos_nxt = lnk_r.pos + 8'h01;
        end
        fbit_slot = !lnk_r.shadow.e1_mode && pos_nxt == rcmc_pkg::FRAME_FIRST_BIT;
        // T1 channels start one bit late, behind the F-bit
        ch_pos = lnk_r.shadow.e1_mode ? pos_nxt : pos_nxt - rcmc_pkg::T1_FBIT_SKIP;
        ch_idx = ch_pos[7:3];
        bit_idx = ch_pos[2:0];
    end

    always_comb begin
        lnk_nxt = lnk_r;
        lnk_nxt.req_s1 = sys_r.req_tgl;
        lnk_nxt.req_s2 = lnk_r.req_s1;
        lnk_nxt.pos = pos_nxt;
        // configuration word arrives; held stable by the pending flag
        if (lnk_r.req_s2 != lnk_r.seen) begin
            lnk_nxt.seen = lnk_r.req_s2;
            lnk_nxt.shadow = sys_r.hold;
        end
        if (fbit_slot) begin
            lnk_nxt.rx_channel_marker = 1'b0;
            lnk_nxt.gap_gate = lnk_r.shadow.gap_fbit_en;
            lnk_nxt.lsb_strobe = 1'b0;
        end else begin
            if (bit_idx == rcmc_pkg::CH_FIRST_BIT) begin
                lnk_nxt.rx_channel_marker = lnk_r.shadow.marker_mask[ch_idx];
                lnk_nxt.gap_gate = lnk_r.shadow.gap_channel_en[ch_idx];
            end
            lnk_nxt.lsb_strobe = bit_idx == rcmc_pkg::CH_LSB_BIT;
        end
    end

    always_ff @(posedge timing_clk or posedge RESET) begin
        if (RESET) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // both modes on the timing clock
    // gapped or channel clock choice
    // gate moves on the rising edge while the high phase is masked: no glitch
    assign rx_channel_clock_out = lnk_r.shadow.gapped_clock_select ?
        (lnk_r.gap_gate & ~timing_clk) : lnk_r.lsb_strobe;

    assign RX_CHANNEL_OUT = lnk_r.shadow.clock_out_select ?
        rx_channel_clock_out : lnk_r.rx_channel_marker;

    // assertions; link checks are off while reset is high
    sequence chan_start_s;
        !fbit_slot && bit_idx == rcmc_pkg::CH_FIRST_BIT;
    endsequence

    sequence chan_body_s;
        !fbit_slot && bit_idx != rcmc_pkg::CH_FIRST_BIT;
    endsequence

    sequence lsb_then_quiet_s;
        lnk_r.lsb_strobe ##1 (!lnk_r.lsb_strobe && !RX_FRAME_SYNC) [*7];
    endsequence

    frame_wrap_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (!lnk_r.shadow.e1_mode && !RX_FRAME_SYNC && lnk_r.pos == rcmc_pkg::T1_LAST_BIT)
        |=> lnk_r.pos == rcmc_pkg::FRAME_FIRST_BIT)
        else $error("T1 frame did not wrap after last bit");

    marker_sample_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (chan_start_s ##0 (lnk_r.req_s2 == lnk_r.seen))
        |=> lnk_r.rx_channel_marker == $past(lnk_r.shadow.marker_mask[ch_idx]))
        else $error("marker not loaded from its channel bit");

    marker_hold_a: assert property (@(posedge timing_clk) disable iff (RESET)
        chan_body_s |=> $stable(lnk_r.rx_channel_marker))
        else $error("marker changed inside a channel");

    lsb_spacing_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (lnk_r.shadow.e1_mode && $stable(lnk_r.shadow.e1_mode)
            && lnk_r.lsb_strobe && !RX_FRAME_SYNC)
        |-> ##1 (!lnk_r.lsb_strobe [*7]) ##1 lnk_r.lsb_strobe or ##[1:8] RX_FRAME_SYNC)
        else $error("channel clock not one pulse per eight bits");

    lsb_quiet_a: assert property (@(posedge timing_clk) disable iff (RESET)
        lsb_then_quiet_s |-> ##1 (lnk_r.lsb_strobe || RX_FRAME_SYNC || !lnk_r.shadow.e1_mode))
        else $error("channel clock missed the next LSB");

    fbit_gate_a: assert property (@(posedge timing_clk) disable iff (RESET)
        fbit_slot |=> lnk_r.gap_gate == $past(lnk_r.shadow.gap_fbit_en) && !lnk_r.lsb_strobe)
        else $error("F-bit gate wrong");

    pin_select_a: assert property (@(posedge timing_clk) disable iff (RESET)
        !lnk_r.shadow.clock_out_select |-> RX_CHANNEL_OUT == lnk_r.rx_channel_marker)
        else $error("pin not showing marker in marker mode");

    shadow_load_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (lnk_r.req_s2 != lnk_r.seen) |=> lnk_r.shadow == $past(sys_r.hold))
        else $error("configuration word not taken");

    cross_ack_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(sys_r.pending) |-> ##[1:80] !sys_r.pending)
        else $error("configuration handshake stalled");

    gap_sample_a: assert property (@(posedge timing_clk) disable iff (RESET)
        chan_start_s |=> lnk_r.gap_gate == $past(lnk_r.shadow.gap_channel_en[ch_idx]))
        else $error("gate not loaded from its channel bit");

    gap_hold_a: assert property (@(posedge timing_clk) disable iff (RESET)
        chan_body_s |=> $stable(lnk_r.gap_gate))
        else $error("gate changed inside a channel");

    fbit_marker_a: assert property (@(posedge timing_clk) disable iff (RESET)
        fbit_slot |=> !lnk_r.rx_channel_marker)
        else $error("marker high during the F-bit");

    pos_advance_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (!RX_FRAME_SYNC && lnk_r.pos != last_bit)
        |=> lnk_r.pos == 8'($past(lnk_r.pos) + 8'h01))
        else $error("bit position did not advance");

    sync_start_a: assert property (@(posedge timing_clk) disable iff (RESET)
        RX_FRAME_SYNC |=> lnk_r.pos == rcmc_pkg::FRAME_FIRST_BIT)
        else $error("frame sync did not restart the frame");

    e1_wrap_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (lnk_r.shadow.e1_mode && !RX_FRAME_SYNC && lnk_r.pos == rcmc_pkg::E1_LAST_BIT)
        |=> lnk_r.pos == rcmc_pkg::FRAME_FIRST_BIT)
        else $error("E1 frame did not wrap after last bit");

    strobe_pin_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (lnk_r.shadow.clock_out_select && !lnk_r.shadow.gapped_clock_select)
        |-> RX_CHANNEL_OUT == lnk_r.lsb_strobe)
        else $error("pin not showing LSB strobe in channel clock mode");

    gap_pin_a: assert property (@(posedge timing_clk) disable iff (RESET)
        (lnk_r.shadow.clock_out_select && lnk_r.shadow.gapped_clock_select)
        |-> RX_CHANNEL_OUT == lnk_r.gap_gate)
        else $error("pin not showing gapped clock in low phase");
endmodule : rcmc_top

// ===== shared/rcmc_pkg.sv
// shared constants and carriers for the receive channel marker/clock output
package rcmc_pkg;
    localparam int unsigned T1_CHANNELS = 24;
    localparam int unsigned E1_CHANNELS = 32;
    localparam logic [7:0] T1_LAST_BIT = 8'hC0;
    localparam logic [7:0] E1_LAST_BIT = 8'hFF;
    localparam logic [7:0] FRAME_FIRST_BIT = 8'h00;
    localparam logic [2:0] CH_FIRST_BIT = 3'h0;
    localparam logic [2:0] CH_LSB_BIT = 3'h7;
    localparam logic [7:0] T1_FBIT_SKIP = 8'h01;
    localparam int unsigned GAP_KHZ_PER_CH = 64;
    localparam int unsigned T1_CHCLK_KHZ = 192;
    localparam int unsigned E1_CHCLK_KHZ = 256;

    // configuration word carried from the system domain to the link domain
    typedef struct packed {
        logic e1_mode;
        logic clock_out_select;
        logic gapped_clock_select;
        logic gap_fbit_en;
        logic [E1_CHANNELS-1:0] marker_mask;
        logic [E1_CHANNELS-1:0] gap_channel_en;
    } rcmc_cfg_s;

    localparam rcmc_cfg_s CFG_RESET = '0;

    typedef struct packed {
        rcmc_cfg_s hold;
        logic req_tgl;
        logic ack_s1;
        logic ack_s2;
        logic pending;
    } rcmc_sys_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic seen;
        rcmc_cfg_s shadow;
        logic [7:0] pos;
        logic rx_channel_marker;
        logic gap_gate;
        logic lsb_strobe;
    } rcmc_link_s;
endpackage : rcmc_pkg

// ===== sim/rcmc_rx_partner.sv
// downstream serial controller model counting clock pulses on the channel output
`timescale 1ns/10ps
module rcmc_rx_partner (
    input wire logic clr,
    input wire logic serial_clk,
    output logic [8:0] pulse_count
);
    always @(posedge serial_clk or posedge clr) begin
        if (clr) begin
            pulse_count <= 9'h000;
        end else begin
            pulse_count <= pulse_count + 9'h001;
        end
    end
endmodule : rcmc_rx_partner

// ===== sim/rcmc_top_tb.sv
// self-checking bench for the receive channel marker/clock output
`timescale 1ns/10ps
module rcmc_top_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic line_clk = 1'b0;
    logic sysx_clk = 1'b0;
    logic es = 1'b0;
    logic sync = 1'b0;
    logic clr = 1'b0;
    rcmc_pkg::rcmc_cfg_s cfg = rcmc_pkg::CFG_RESET;
    wire logic pin;
    wire logic [8:0] pulses;
    wire logic tclk = es ? sysx_clk : line_clk;
    int error_cnt = 0;
    int check_count = 0;

    rcmc_top i_dut (.SYS_CLK(sys_clk), .RESET(rst), .RX_LINE_CLOCK(line_clk),
        .RX_SYSTEM_CLOCK(sysx_clk), .RX_ES_ENABLE(es), .RX_FRAME_SYNC(sync),
        .E1_MODE(cfg.e1_mode), .CLOCK_OUT_SELECT(cfg.clock_out_select),
        .GAPPED_CLOCK_SELECT(cfg.gapped_clock_select), .GAP_FBIT_EN(cfg.gap_fbit_en),
        .MARKER_MASK(cfg.marker_mask), .GAP_CHANNEL_EN(cfg.gap_channel_en),
        .RX_CHANNEL_OUT(pin));
    rcmc_rx_partner i_rx (.clr(clr), .serial_clk(pin), .pulse_count(pulses));

    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #62.5 line_clk = ~line_clk;
    end
    // system clock edges late against line clock, so a wrong pick shows
    initial begin
        #103;
        forever #62.5 sysx_clk = ~sysx_clk;
    end

    function automatic logic exp_bit(int pos, rcmc_pkg::rcmc_cfg_s c);
        int ch;
        int b;
        logic fb;
        fb = !c.e1_mode && pos == 0;
        ch = c.e1_mode ? pos / 8 : (pos - 1) / 8;
        b = c.e1_mode ? pos % 8 : (pos - 1) % 8;
        if (!c.clock_out_select) return fb ? 1'b0 : c.marker_mask[ch];
        if (!c.gapped_clock_select) return !fb && b == 7;
        return fb ? c.gap_fbit_en : c.gap_channel_en[ch];
    endfunction : exp_bit

    // gapped mode gives one pulse per bit of each enabled channel
    function automatic logic [8:0] exp_cnt(rcmc_pkg::rcmc_cfg_s c);
        logic [31:0] m;
        m = c.e1_mode ? 32'hffff_ffff : 32'h00ff_ffff;
        if (!c.gapped_clock_select) return 9'($countones(m));
        return 9'(8 * $countones(c.gap_channel_en & m) + (!c.e1_mode && c.gap_fbit_en));
    endfunction : exp_cnt

    task automatic chk_bit(logic got, logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_cnt(logic [8:0] got, logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t pulses got %h exp %h", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // one frame from the edge that takes sync; samples high then low half of every bit
    task automatic run_frame(logic check);
        int n;
        n = cfg.e1_mode ? 256 : 193;
        for (int p = 0; p < n; p++) begin
            @(posedge tclk);
            // next sync lands on the natural wrap, so frames stay n bits long
            sync <= (p == n - 1);
            #31;
            if (check && p == 0 && cfg.clock_out_select) begin
                chk_cnt(pulses, exp_cnt(cfg));
            end
            if (p == 0) begin
                clr = 1'b1;
                #1 clr = 1'b0;
            end
            if (check) begin
                chk_bit(pin, (cfg.clock_out_select && cfg.gapped_clock_select) ? 1'b0 : exp_bit(p, cfg));
            end
            #62;
            if (check) begin
                chk_bit(pin, exp_bit(p, cfg));
            end
        end
    endtask : run_frame

    task automatic one_case(logic e1, int mode, logic corner);
        rcmc_pkg::rcmc_cfg_s c;
        c.e1_mode = e1;
        c.clock_out_select = mode != 0;
        c.gapped_clock_select = mode == 2;
        c.gap_fbit_en = corner | 1'($urandom);
        c.marker_mask = corner ? 32'hffff_ffff : $urandom;
        c.gap_channel_en = corner ? 32'hffff_ffff : $urandom;
        @(posedge sys_clk);
        cfg <= c;
        @(posedge tclk);
        sync <= 1'b1;
        repeat (2) run_frame(1'b0);
        repeat (2) run_frame(1'b1);
    endtask : one_case

    // watchdog: a stuck run counts as a mismatch
    initial begin
        repeat (80000) @(posedge sys_clk);
        error_cnt++;
        $display("[ERR] %0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
        finish_test();
    end

    initial begin
        void'($urandom(32'h2a50));
        for (int e = 0; e < 2; e++) begin
            @(posedge sys_clk);
            rst <= 1'b1;
            es <= e[0];
            sync <= 1'b0;
            cfg <= rcmc_pkg::CFG_RESET;
            repeat (6) @(posedge sys_clk);
            rst <= 1'b0;
            for (int t = 0; t < 2; t++) begin
                for (int m = 0; m < 3; m++) begin
                    one_case(t[0], m, e[0]);
                end
            end
        end
        finish_test();
    end
endmodule : rcmc_top_tb
